// ==== inc/fjs_defines.svh ====
// constants for the fold and jam supervisor
// Contract
// - letter/A4 long-edge stacks of ten or more sheets are folded twice
// - double fold: after 20 mm grip, run rollers in reverse for 20 mm
// - then roll forward to deliver, push plate returns home meanwhile
// - single fold: plate holds until 10 mm gripped, then returns home
// - any detected jam condition raises the jam signal to the host
// - inlet delay jam: sensor 1 late after finisher inlet sensor
// - inlet stationary jam: sensors still covered after 1.5 paper lengths
// - the sensors checked for inlet stationary depend on paper size
// - delivery delay jam: delivery sensor late after push plate top
// - vertical path still covered after half length minus 130 plus 50 mm
// - delivery sensor still covered after a set feed amount
// - at power-on any path sensor covered is a jam
// - an open door or cover during operation is a jam
// - stitcher clockwise: home must return within 0.5 s after leaving
// - stitcher counterclockwise: home arriving within 0.5 s is a jam
// - positioning plate sensor not covered at push start is a jam
// - on closing all doors, paper at vertical path re-raises jam
`ifndef FJS_DEFINES_SVH
`define FJS_DEFINES_SVH

// ---------------------------------------------------------------
// clock and time base
// ---------------------------------------------------------------
`define FJS_CLK_PERIOD_NS 25
`define FJS_TICK_PERIOD_NS 1000000
`define FJS_TICK_CYCLES (`FJS_TICK_PERIOD_NS / `FJS_CLK_PERIOD_NS)
`define FJS_STITCH_WIN_S 0.5
`define FJS_STITCH_WIN_TICKS ($rtoi(`FJS_STITCH_WIN_S * 1.0e9 / `FJS_TICK_PERIOD_NS))
`define FJS_INLET_DELAY_MS 1000
`define FJS_DLV_DELAY_MS 1000
`define FJS_POR_SETTLE 3'h5

// ---------------------------------------------------------------
// feed distances
// ---------------------------------------------------------------
`define FJS_PULSES_PER_MM 1
`define FJS_DOUBLE_MIN_SHEETS 8'h0a
`define FJS_GRIP_DOUBLE_MM 20
`define FJS_GRIP_SINGLE_MM 10
`define FJS_REVERSE_MM 20
`define FJS_VPATH_OFFSET_MM 130
`define FJS_VPATH_MARGIN_MM 50
`define FJS_DLV_STAY_MM 400

// ---------------------------------------------------------------
// jam cause bit positions
// ---------------------------------------------------------------
`define FJS_JAM_INLET_DELAY 0
`define FJS_JAM_INLET_STAY 1
`define FJS_JAM_DLV_DELAY 2
`define FJS_JAM_VPATH_STAY 3
`define FJS_JAM_DLV_STAY 4
`define FJS_JAM_POWER_ON 5
`define FJS_JAM_DOOR 6
`define FJS_JAM_STAPLE_CW 7
`define FJS_JAM_STAPLE_CCW 8
`define FJS_JAM_FEED_DELAY 9
`define FJS_JAM_BAD_REMOVAL 10
`define FJS_JAM_CAUSES 11
`define FJS_PIN_COUNT 16

`endif

// ==== inc/fjs_pkg.sv ====
// types shared by the fold and jam supervisor
package fjs_pkg;
    typedef enum logic [1:0] {
        FJS_SIZE_A3_LD = 2'b00,
        FJS_SIZE_B4 = 2'b01,
        FJS_SIZE_A4R_LTR = 2'b10,
        FJS_SIZE_OTHER = 2'b11
    } fjs_size_t;

    typedef enum logic [2:0] {
        FJS_ST_IDLE = 3'b000,
        FJS_ST_PUSH = 3'b001,
        FJS_ST_GRIP = 3'b010,
        FJS_ST_REVERSE = 3'b011,
        FJS_ST_DELIVER = 3'b100
    } fjs_state_t;
endpackage : fjs_pkg

// ==== verilog/fjs_sync.sv ====
// three-stage synchroniser bank with agreement filter for pin inputs
`include "fjs_defines.svh"
module fjs_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`FJS_PIN_COUNT-1:0] pins,
    output logic [`FJS_PIN_COUNT-1:0] synced
);
    import fjs_pkg::*;

    logic [`FJS_PIN_COUNT-1:0] stage1;
    logic [`FJS_PIN_COUNT-1:0] stage2;
    logic [`FJS_PIN_COUNT-1:0] stage3;
    // -----------------------------------------------------------
    // synchroniser chain
    // -----------------------------------------------------------
    // stage1 feeds stage2 only; a change is taken once stages 2 and 3 agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            synced <= '0;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
            synced <= (stage2 & stage3) | (synced & (stage2 | stage3));
        end
    end
endmodule : fjs_sync

// ==== verilog/fjs_supervisor.sv ====
// fold sequencer and jam supervisor for the saddle stitch and fold unit
`include "fjs_defines.svh"
module fjs_supervisor #(
    parameter int TICK_CYCLES = `FJS_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic positioning_plate_paper_sensor,
    input wire logic delivery_paper_sensor,
    input wire logic push_plate_home_sensor,
    input wire logic push_plate_top_sensor,
    input wire logic vertical_path_sensor,
    input wire logic saddle_paper_sensor_1,
    input wire logic saddle_paper_sensor_2,
    input wire logic saddle_paper_sensor_3,
    input wire logic finisher_inlet_sensor,
    input wire logic front_door_sensor,
    input wire logic outlet_cover_sensor,
    input wire logic inlet_cover_sensor,
    input wire logic front_stitcher_home_sensor,
    input wire logic rear_stitcher_home_sensor,
    input wire logic feed_motor_clock,
    input wire logic fold_motor_clock,
    input wire logic front_stitcher_motor_cw,
    input wire logic front_stitcher_motor_ccw,
    input wire logic rear_stitcher_motor_cw,
    input wire logic rear_stitcher_motor_ccw,
    input wire logic host_operating,
    input wire logic fold_start,
    input wire fjs_pkg::fjs_size_t stack_size,
    input wire logic [7:0] sheet_count,
    input wire logic [10:0] paper_length_mm,
    output logic fold_motor_fwd,
    output logic fold_motor_rev,
    output logic push_motor_run,
    output logic push_motor_to_home,
    output logic fold_busy,
    output logic fold_done,
    output logic jam,
    output logic [`FJS_JAM_CAUSES-1:0] jam_causes
);
    import fjs_pkg::*;

    // mm to motor pulses, truncated to the 12-bit counters
    function automatic logic [11:0] mm_pulses(input logic [11:0] mm);
        mm_pulses = 12'(mm * `FJS_PULSES_PER_MM);
    endfunction : mm_pulses

    // ---------------------------------------------------------------
    // pin synchronisation and edges
    // ---------------------------------------------------------------
    logic [`FJS_PIN_COUNT-1:0] s_now;
    logic [`FJS_PIN_COUNT-1:0] s_prev;
    wire [`FJS_PIN_COUNT-1:0] s_rise = s_now & ~s_prev;
    wire [`FJS_PIN_COUNT-1:0] s_fall = ~s_now & s_prev;
    logic pos_s, dlv_s, home_s, top_s, vp_s, sp1_s, sp2_s, sp3_s, inl_s;
    logic door_s, outc_s, inc_s, fhome_s, rhome_s, feedc_s, foldc_s;
    logic dlv_r, top_r, sp1_r, inl_r, feed_p, fold_p;
    logic [1:0] home_rise, home_fall;

    fjs_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pins({positioning_plate_paper_sensor, delivery_paper_sensor, push_plate_home_sensor,
               push_plate_top_sensor, vertical_path_sensor, saddle_paper_sensor_1,
               saddle_paper_sensor_2, saddle_paper_sensor_3, finisher_inlet_sensor,
               front_door_sensor, outlet_cover_sensor, inlet_cover_sensor,
               front_stitcher_home_sensor, rear_stitcher_home_sensor,
               feed_motor_clock, fold_motor_clock}),
        .synced(s_now)
    );

    assign {pos_s, dlv_s, home_s, top_s, vp_s, sp1_s, sp2_s, sp3_s, inl_s,
            door_s, outc_s, inc_s, fhome_s, rhome_s, feedc_s, foldc_s} = s_now;
    assign dlv_r = s_rise[14];
    assign top_r = s_rise[12];
    assign sp1_r = s_rise[10];
    assign inl_r = s_rise[7];
    assign home_rise = s_rise[3:2];
    assign home_fall = s_fall[3:2];
    assign feed_p = s_rise[1];  // one pulse per feed motor clock rising edge
    assign fold_p = s_rise[0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) s_prev <= '0;
        else s_prev <= s_now;
    end

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    logic [15:0] div_cnt;
    wire tick = (div_cnt == 16'(TICK_CYCLES - 1));  // one pulse per ms

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) div_cnt <= '0;
        else div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
    end

    // ---------------------------------------------------------------
    // fold sequencer
    // ---------------------------------------------------------------
    fjs_state_t state, next_state;
    logic double_mode;
    logic [11:0] fold_cnt;
    wire door_open = door_s | outc_s | inc_s;
    wire want_double = (stack_size == FJS_SIZE_A4R_LTR) && (sheet_count >= `FJS_DOUBLE_MIN_SHEETS);
    wire start_ok = fold_start && (state == FJS_ST_IDLE) && !jam && pos_s;
    wire feed_delay_jam = fold_start && (state == FJS_ST_IDLE) && !jam && !pos_s;
    wire [11:0] grip_lim = double_mode ? mm_pulses(12'(`FJS_GRIP_DOUBLE_MM))
                                       : mm_pulses(12'(`FJS_GRIP_SINGLE_MM));
    wire grip_done = fold_cnt >= grip_lim;
    wire rev_done = fold_cnt >= mm_pulses(12'(`FJS_REVERSE_MM));
    wire dlv_done = home_s && (fold_cnt >= mm_pulses({1'b0, paper_length_mm}));

    // sequencing stops at once on any jam, so no roller or plate motion follows
    always_comb begin
        next_state = state;
        unique case (state)
            FJS_ST_IDLE: if (start_ok) next_state = FJS_ST_PUSH;
            FJS_ST_PUSH: if (top_s) next_state = FJS_ST_GRIP;
            FJS_ST_GRIP: if (grip_done) next_state = double_mode ? FJS_ST_REVERSE : FJS_ST_DELIVER;
            FJS_ST_REVERSE: if (rev_done) next_state = FJS_ST_DELIVER;
            FJS_ST_DELIVER: if (dlv_done) next_state = FJS_ST_IDLE;
            default: next_state = FJS_ST_IDLE;
        endcase
        if (jam) next_state = FJS_ST_IDLE;
    end

    // motor commands: plate holds at the leading edge through grip and reverse
    wire cmd_fwd = !jam && (state == FJS_ST_PUSH || state == FJS_ST_GRIP || state == FJS_ST_DELIVER);
    wire cmd_rev = !jam && (state == FJS_ST_REVERSE);
    wire cmd_plate = !jam && (state == FJS_ST_PUSH || (state == FJS_ST_DELIVER && !home_s));
    wire cmd_home = (state == FJS_ST_DELIVER);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= FJS_ST_IDLE;
            double_mode <= 1'b0;
            fold_cnt <= '0;
        end else begin
            state <= next_state;
            if (start_ok) double_mode <= want_double;
            if (next_state != state) fold_cnt <= '0;
            else if (fold_p) fold_cnt <= fold_cnt + 12'h001;
        end
    end

    // registered outputs, one cycle behind the commands
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {fold_motor_fwd, fold_motor_rev, push_motor_run, push_motor_to_home} <= 4'h0;
            {fold_busy, fold_done} <= 2'b00;
        end else begin
            {fold_motor_fwd, fold_motor_rev, push_motor_run, push_motor_to_home} <=
                {cmd_fwd, cmd_rev, cmd_plate, cmd_home};
            fold_busy <= (next_state != FJS_ST_IDLE);
            fold_done <= (state == FJS_ST_DELIVER) && dlv_done && !jam;
        end
    end

    // ---------------------------------------------------------------
    // inlet and delivery monitors
    // ---------------------------------------------------------------
    logic inl_arm, dd_arm, ist_arm, dst_arm;
    logic [11:0] inl_ms, dd_ms, ist_cnt, dst_cnt;
    // checked sensors by size: longer stacks cover fewer sensors
    wire [2:0] ist_mask = (stack_size == FJS_SIZE_A4R_LTR) ? 3'h7 : (stack_size == FJS_SIZE_B4) ? 3'h3 : 3'h1;
    wire [11:0] ist_lim = mm_pulses(12'({1'b0, paper_length_mm} + 12'({2'b00, paper_length_mm[10:1]})));
    wire [11:0] half_len = {2'b00, paper_length_mm[10:1]};
    wire [11:0] vp_mm = (half_len > 12'(`FJS_VPATH_OFFSET_MM)) ? half_len - 12'(`FJS_VPATH_OFFSET_MM) : 12'h000;
    wire [11:0] vp_lim = mm_pulses(vp_mm + 12'(`FJS_VPATH_MARGIN_MM));
    wire [11:0] dst_lim = mm_pulses(12'(`FJS_DLV_STAY_MM));
    wire inl_jam = inl_arm && tick && (inl_ms == 12'(`FJS_INLET_DELAY_MS - 1));
    wire dd_jam = dd_arm && tick && (dd_ms == 12'(`FJS_DLV_DELAY_MS - 1));
    wire ist_hit = ist_arm && (ist_cnt >= ist_lim);
    wire ist_jam = ist_hit && |({sp3_s, sp2_s, sp1_s} & ist_mask);
    wire vp_jam = dst_arm && (dst_cnt == vp_lim) && vp_s;
    wire dst_jam = dst_arm && (dst_cnt >= dst_lim) && dlv_s;

    // each window arms on its start edge and disarms on timeout or jam; all but the inlet stationary one also disarm on success
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {inl_arm, dd_arm, ist_arm, dst_arm} <= 4'h0;
            {inl_ms, dd_ms, ist_cnt, dst_cnt} <= '0;
        end else begin
            inl_arm <= !jam && !sp1_r && !inl_jam && (inl_arm || inl_r);
            inl_ms <= inl_r ? 12'h000 : (tick ? inl_ms + 12'h001 : inl_ms);
            dd_arm <= !jam && !dlv_r && !dd_jam && (dd_arm || top_r);
            dd_ms <= top_r ? 12'h000 : (tick ? dd_ms + 12'h001 : dd_ms);
            ist_arm <= !jam && !ist_hit && (ist_arm || sp1_r);
            ist_cnt <= sp1_r ? 12'h000 : (feed_p ? ist_cnt + 12'h001 : ist_cnt);
            dst_arm <= !jam && dlv_s && !dst_jam && (dst_arm || dlv_r);
            dst_cnt <= dlv_r ? 12'h000 : (feed_p && dst_cnt != 12'hfff ? dst_cnt + 12'h001 : dst_cnt);
        end
    end

    // ---------------------------------------------------------------
    // stitcher monitors
    // ---------------------------------------------------------------
    wire [1:0] st_cw = {front_stitcher_motor_cw, rear_stitcher_motor_cw};
    wire [1:0] st_ccw = {front_stitcher_motor_ccw, rear_stitcher_motor_ccw};
    logic [1:0] cw_arm, ccw_arm, ccw_prev;
    logic [11:0] cw_ms [2];
    logic [11:0] ccw_ms [2];
    logic [1:0] cw_jam, ccw_jam;

    // the counterclockwise check flags a home arrival inside the window
    for (genvar i = 0; i < 2; i++) begin : g_stitch
        assign cw_jam[i] = cw_arm[i] && tick && (cw_ms[i] == 12'(`FJS_STITCH_WIN_TICKS - 1));
        assign ccw_jam[i] = ccw_arm[i] && home_rise[i];
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                {cw_arm[i], ccw_arm[i], ccw_prev[i]} <= 3'b000;
                cw_ms[i] <= '0;
                ccw_ms[i] <= '0;
            end else begin
                ccw_prev[i] <= st_ccw[i];
                cw_arm[i] <= !jam && st_cw[i] && !home_rise[i] && !cw_jam[i] && (cw_arm[i] || home_fall[i]);
                cw_ms[i] <= home_fall[i] ? 12'h000 : (tick ? cw_ms[i] + 12'h001 : cw_ms[i]);
                ccw_arm[i] <= !jam && !ccw_jam[i] && (st_ccw[i] && !ccw_prev[i] ||
                              ccw_arm[i] && !(tick && ccw_ms[i] == 12'(`FJS_STITCH_WIN_TICKS - 1)));
                ccw_ms[i] <= (st_ccw[i] && !ccw_prev[i]) ? 12'h000 : (tick ? ccw_ms[i] + 12'h001 : ccw_ms[i]);
            end
        end
    end

    // ---------------------------------------------------------------
    // power-on check, jam latch and recovery
    // ---------------------------------------------------------------
    logic [2:0] por_cnt;
    logic seen_open;
    wire por_check = (por_cnt == `FJS_POR_SETTLE - 3'h1);  // after the filters settle
    wire path_busy = sp1_s | sp2_s | sp3_s | vp_s | dlv_s;
    wire operating = host_operating || (state != FJS_ST_IDLE);
    wire closed_now = jam && seen_open && !door_open;
    wire bad_removal = closed_now && vp_s;
    logic [`FJS_JAM_CAUSES-1:0] jam_event;

    always_comb begin
        jam_event = '0;
        jam_event[`FJS_JAM_INLET_DELAY] = inl_jam;
        jam_event[`FJS_JAM_INLET_STAY] = ist_jam;
        jam_event[`FJS_JAM_DLV_DELAY] = dd_jam;
        jam_event[`FJS_JAM_VPATH_STAY] = vp_jam;
        jam_event[`FJS_JAM_DLV_STAY] = dst_jam;
        jam_event[`FJS_JAM_POWER_ON] = por_check && path_busy;
        jam_event[`FJS_JAM_DOOR] = operating && door_open;
        jam_event[`FJS_JAM_STAPLE_CW] = |cw_jam;
        jam_event[`FJS_JAM_STAPLE_CCW] = |ccw_jam;
        jam_event[`FJS_JAM_FEED_DELAY] = feed_delay_jam;
        jam_event[`FJS_JAM_BAD_REMOVAL] = bad_removal;
    end

    wire clear_ok = closed_now && !vp_s;

    // a new cause in the clearing cycle keeps the latch set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            por_cnt <= '0;
            seen_open <= 1'b0;
            jam <= 1'b0;
            jam_causes <= '0;
        end else begin
            if (por_cnt != `FJS_POR_SETTLE) por_cnt <= por_cnt + 3'h1;
            seen_open <= jam && !closed_now && (seen_open || door_open);
            jam <= (|jam_event) || (jam && !clear_ok);
            jam_causes <= jam_event | (clear_ok ? '0 : jam_causes);
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_double_choice: assert property (start_ok |=> double_mode == $past(want_double))
        else $error("fold count choice wrong");
    a_reverse_span: assert property ($rose(cmd_rev) |-> double_mode && $past(fold_cnt) >= 12'(`FJS_GRIP_DOUBLE_MM))
        else $error("reverse without double grip");
    a_plate_home: assert property (state == FJS_ST_DELIVER && !home_s && !jam |-> cmd_plate && cmd_home)
        else $error("plate not returning in delivery");
    a_single_hold: assert property (state == FJS_ST_GRIP |-> !cmd_plate ##1 (state != FJS_ST_PUSH))
        else $error("plate moved during grip");
    a_jam_raise: assert property (|jam_event |=> jam && (jam_causes & $past(jam_event)) == $past(jam_event))
        else $error("jam cause not latched");
    a_por_jam: assert property (por_check && path_busy |=> jam [*3])
        else $error("power-on jam missed");
    a_door_jam: assert property (operating && door_open |=> jam ##1 state == FJS_ST_IDLE)
        else $error("door jam missed");
    a_feed_delay: assert property (feed_delay_jam |=> jam && state == FJS_ST_IDLE)
        else $error("feed delay jam missed");
    a_bad_removal: assert property (bad_removal |=> jam && !seen_open)
        else $error("faulty removal not flagged");
    a_jam_hold: assert property (jam && !clear_ok |=> jam && !fold_motor_fwd ##1 !fold_motor_fwd)
        else $error("jam dropped or motion kept");

    c_double_fold: cover property (state == FJS_ST_REVERSE ##[1:1000] fold_done);
    c_single_fold: cover property (start_ok && !want_double ##[1:1000] fold_done);
    c_jam_cleared: cover property (jam ##[1:1000] !jam);
endmodule : fjs_supervisor

// ==== bench/fjs_host_model.sv ====
// host copier controller model: runs jobs and counts jam reports
module fjs_host_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic jam,
    input wire logic run_req,
    output logic host_operating,
    output int jam_reports
);
    timeunit 1ns;
    timeprecision 1ps;
    logic jam_seen;
    // the host stops copying as soon as a jam is reported, so doors may open safely
    assign host_operating = run_req & ~jam;
    // count rising edges only: a re-raised latched jam is not a new report
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            jam_seen <= 1'b0;
            jam_reports <= 0;
        end else begin
            jam_seen <= jam;
            if (jam && !jam_seen) jam_reports <= jam_reports + 1;
        end
    end
endmodule : fjs_host_model

// ==== bench/fold_and_jam_supervisor_bench.sv ====
// self-checking bench for the fold and jam supervisor
`include "fjs_defines.svh"
module fold_and_jam_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fjs_pkg::*;
    logic clk = 1'b0;
    logic rstn, pos_s, dlv_s, home_s, top_s, vp_s, s1, s2, s3, inl_s, door_f, door_o, door_i;
    logic fh_s, rh_s, feed_clk, fold_clk, fcw, fccw, rcw, rccw, run_req, fold_start;
    fjs_size_t size;
    logic [7:0] sheets;
    logic [10:0] len;
    logic host_op, fwd, rev, prun, phome, busy, done, jam;
    logic [`FJS_JAM_CAUSES-1:0] causes;
    int n_fail = 0;
    int n_checks = 0;
    int reports;

    always #12.5 clk = ~clk;

    // short tick so the 500 ms and 1000 ms windows last 2000 and 4000 cycles
    fjs_supervisor #(.TICK_CYCLES(4)) i_fjs_supervisor (.clk(clk), .rstn(rstn),
        .positioning_plate_paper_sensor(pos_s), .delivery_paper_sensor(dlv_s), .push_plate_home_sensor(home_s),
        .push_plate_top_sensor(top_s), .vertical_path_sensor(vp_s), .saddle_paper_sensor_1(s1),
        .saddle_paper_sensor_2(s2), .saddle_paper_sensor_3(s3), .finisher_inlet_sensor(inl_s),
        .front_door_sensor(door_f), .outlet_cover_sensor(door_o), .inlet_cover_sensor(door_i),
        .front_stitcher_home_sensor(fh_s), .rear_stitcher_home_sensor(rh_s), .feed_motor_clock(feed_clk),
        .fold_motor_clock(fold_clk), .front_stitcher_motor_cw(fcw), .front_stitcher_motor_ccw(fccw),
        .rear_stitcher_motor_cw(rcw), .rear_stitcher_motor_ccw(rccw), .host_operating(host_op),
        .fold_start(fold_start), .stack_size(size), .sheet_count(sheets), .paper_length_mm(len),
        .fold_motor_fwd(fwd), .fold_motor_rev(rev), .push_motor_run(prun), .push_motor_to_home(phome),
        .fold_busy(busy), .fold_done(done), .jam(jam), .jam_causes(causes));

    fjs_host_model i_fjs_host_model (.clk(clk), .rstn(rstn), .jam(jam), .run_req(run_req),
        .host_operating(host_op), .jam_reports(reports));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    // one pulse is 4 cycles high and 4 low, twice the 2 cycles the filter needs
    task automatic pulses(input bit on_fold, input int n);
        repeat (n) begin
            @(posedge clk) fold_clk <= on_fold;
            feed_clk <= !on_fold;
            wt(4);
            fold_clk <= 1'b0;
            feed_clk <= 1'b0;
            wt(3);
        end
    endtask : pulses

    task automatic expect_jam(input logic [10:0] mask);
        wt(10);
        check("jam", jam, 1'b1);
        check("causes", causes, mask);
        check("motors off", {fwd, rev, prun}, 3'h0);
    endtask : expect_jam

    // host stops first, then a door cycle releases the latch
    task automatic clear_jam;
        run_req <= 1'b0;
        door_f <= 1'b1;
        wt(10);
        door_f <= 1'b0;
        wt(10);
        check("jam clear", jam, 1'b0);
        check("causes clear", causes, 11'h0);
        run_req <= 1'b1;
    endtask : clear_jam

    task automatic fold(input fjs_size_t sz, input logic [7:0] n, input bit dbl);
        @(posedge clk) size <= sz;
        sheets <= n;
        pos_s <= 1'b1;
        home_s <= 1'b0;
        // the plate sensor must clear the pin filter before the start pulse
        wt(6);
        fold_start <= 1'b1;
        @(posedge clk) fold_start <= 1'b0;
        wt(6);
        check("push out", {busy, prun, phome, fwd}, 4'hd);
        top_s <= 1'b1;
        wt(8);
        check("plate held", prun, 1'b0);
        pulses(1, dbl ? 19 : 9);
        wt(4);
        check("still gripping", {fwd, rev, phome}, 3'h4);
        pulses(1, 1);
        wt(4);
        if (dbl) begin
            check("reverse", {fwd, rev, phome}, 3'h2);
            pulses(1, 19);
            wt(4);
            check("reverse held", rev, 1'b1);
            pulses(1, 1);
            wt(4);
        end
        check("deliver", {fwd, rev, prun, phome}, 4'hb);
        top_s <= 1'b0;
        dlv_s <= 1'b1;
        pulses(1, 20);
        dlv_s <= 1'b0;
        home_s <= 1'b1;
        for (int i = 0; i < 40 && done !== 1'b1; i++) wt(1);
        check("done", done, 1'b1);
        check("no jam", jam, 1'b0);
    endtask : fold

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // ---------------------------------------------------------------
    // scenarios in order; paper sits on the delivery sensor at power-on
    // ---------------------------------------------------------------
    initial begin
        {rstn, pos_s, top_s, vp_s, s1, s2, s3, inl_s, door_f, door_o, door_i} = 11'h0;
        {feed_clk, fold_clk, fcw, fccw, rcw, rccw, run_req, fold_start} = 8'h0;
        {dlv_s, home_s, fh_s, rh_s} = 4'hf;
        size = FJS_SIZE_B4;
        sheets = 8'h00;
        len = 11'h014;
        wt(3);
        rstn <= 1'b1;
        expect_jam(11'h020);
        dlv_s <= 1'b0;
        clear_jam;
        fold(FJS_SIZE_A4R_LTR, 8'h09, 1'b0);
        fold(FJS_SIZE_A4R_LTR, 8'h0a, 1'b1);
        fold(FJS_SIZE_B4, 8'h0a, 1'b0);
        pos_s <= 1'b0;
        wt(6);
        fold_start <= 1'b1;
        @(posedge clk) fold_start <= 1'b0;
        expect_jam(11'h200);
        clear_jam;
        door_o <= 1'b1;
        expect_jam(11'h040);
        vp_s <= 1'b1;
        door_o <= 1'b0;
        expect_jam(11'h440);
        vp_s <= 1'b0;
        clear_jam;
        // inlet and delivery delay windows run side by side and expire together
        inl_s <= 1'b1;
        top_s <= 1'b1;
        wt(3900);
        check("inlet early", jam, 1'b0);
        wt(100);
        expect_jam(11'h005);
        inl_s <= 1'b0;
        top_s <= 1'b0;
        clear_jam;
        s1 <= 1'b1;
        s2 <= 1'b1;
        pulses(0, 10);
        s1 <= 1'b0;
        pulses(0, 19);
        check("stay early", jam, 1'b0);
        pulses(0, 2);
        expect_jam(11'h002);
        s2 <= 1'b0;
        clear_jam;
        // trailing edge stuck at the vertical path sensor, then at the delivery sensor
        vp_s <= 1'b1;
        dlv_s <= 1'b1;
        pulses(0, 49);
        check("vpath early", jam, 1'b0);
        pulses(0, 2);
        expect_jam(11'h008);
        {vp_s, dlv_s} <= 2'b00;
        clear_jam;
        dlv_s <= 1'b1;
        pulses(0, 399);
        check("delivery early", jam, 1'b0);
        pulses(0, 2);
        expect_jam(11'h010);
        dlv_s <= 1'b0;
        clear_jam;
        rcw <= 1'b1;
        rh_s <= 1'b0;
        wt(1000);
        rh_s <= 1'b1;
        fcw <= 1'b1;
        fh_s <= 1'b0;
        wt(1900);
        check("stitch in time", jam, 1'b0);
        wt(200);
        expect_jam(11'h080);
        {fcw, rcw, fh_s, rh_s} <= 4'h2;
        clear_jam;
        rccw <= 1'b1;
        wt(100);
        rh_s <= 1'b1;
        expect_jam(11'h100);
        rccw <= 1'b0;
        clear_jam;
        check("jam reports", reports, 32'd9);
        tally_and_finish;
    end

    // the scenarios need about 12500 cycles
    initial begin
        wt(60000);
        n_fail++;
        tally_and_finish;
    end
endmodule : fold_and_jam_supervisor_bench
